// file: logic/pmrc_pkg.sv
// Operation
// - A rail is off whenever its pin is low and its enable bit is 0.
// - Each rail pin has a filtered sense bit; sense bits raise no event.
// - Registers stay readable and writable while all rail pins are low.
// - Writing the reset register restores every control register to its default.
// - Each rail's power-up slot is reprogrammable through a register.
// - Lockout turns all rails off at once, discharges them, pulls supply-ok low.
// - Raising a converter target steps the reference one code per period.
// - Step size fixed; two-bit ramp field picks 1.33, 2.67, 5.33 or 10.67 us.
// - Target select 0 picks the primary code, 1 the alternate code.
// - A transition starts on select toggle or rewrite of the selected code.
// - Power-good is high while off, low on enable, high once level reached.
// - Power-good falls below 90 percent and recovers above 95 percent.
// - Live power-good bits ignore the assignment and gating bits.
// - Supply-ok is the AND of assigned power-goods, reset and ramp signals.
// - With reset assigned, supply-ok stays low through the power-up sequence.
// - With a ramp signal assigned, supply-ok stays low while that converter rises.
// - A set gating bit pulls supply-ok low whenever that rail is off.
// - Supply-ok is open drain; defaults assign buck two and reset, gate buck two.
// - A three-bit field delays supply-ok release, 0 ms to 512 ms, default 0.
// - Sources are edge detected both ways; converter over-currents only rising.
// - Detected events latch to 1; reading a latched register clears it.
// - Live source registers show the present state of each source.
// - A rail turns on once the sequencer passed its slot and pin or bit high.
// - While the supply is below lockout the control registers and sequencer are held reset; event history is kept.
package pmrc_pkg;

    // ------------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] A_ENABLE = 8'h00;
    localparam logic [7:0] A_SLOT   = 8'h04;
    localparam logic [7:0] A_PRIM   = 8'h08;
    localparam logic [7:0] A_ALT    = 8'h0C;
    localparam logic [7:0] A_TIME   = 8'h10;
    localparam logic [7:0] A_ASSIGN = 8'h14;
    localparam logic [7:0] A_GATE   = 8'h18;
    localparam logic [7:0] A_RESET  = 8'h1C;
    localparam logic [7:0] A_LIVE_A = 8'h20;
    localparam logic [7:0] A_LIVE_B = 8'h24;
    localparam logic [7:0] A_LAT_A  = 8'h28;
    localparam logic [7:0] A_LAT_B  = 8'h2C;
    localparam logic [7:0] A_STATUS = 8'h30;
    localparam logic [7:0] A_REF    = 8'h34;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int F_GO   = 0;
    localparam int F_RATE = 2;
    localparam int F_DLY  = 4;
    localparam int SLOT_W = 3;
    localparam int CODE_W = 8;
    localparam int TMR_W  = 9;
    localparam int NSRC_A = 5;
    localparam int NSRC   = 11;
    localparam logic [10:0] RISE_ONLY = 11'h060;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ    = 25000;
    localparam int SLOT_US    = 128;
    localparam logic [11:0] SLOT_CYC = 12'(SLOT_US * CLK_KHZ / 1000);
    localparam int MS_CYC_DEF = CLK_KHZ;
    localparam int MS_W       = 20;
    localparam int RAMP0_NS   = 1330;
    localparam int RAMP1_NS   = 2670;
    localparam int RAMP2_NS   = 5330;
    localparam int RAMP3_NS   = 10670;
    localparam logic [2:0] SEQ_END = 3'h5;

    // Terminal count of the step timer, one step per period.
    function automatic logic [8:0] ramp_lim(input logic [1:0] r);
        int ns;
        case (r)
            2'h0:    ns = RAMP0_NS;
            2'h1:    ns = RAMP1_NS;
            2'h2:    ns = RAMP2_NS;
            default: ns = RAMP3_NS;
        endcase
        return 9'(ns * CLK_KHZ / 1000000 - 1);
    endfunction

    // Release delay in ms: 0, then 8 doubling up to 512.
    function automatic logic [9:0] dly_ms(input logic [2:0] c);
        return (c == 3'h0) ? 10'h000 : 10'(10'h004 << c);
    endfunction

    // ------------------------------------------------------------------
    // Types and reset values
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  en;
        logic [11:0] slot;
        logic [15:0] prim;
        logic [15:0] alt;
        logic [2:0]  dly;
        logic [1:0]  rate;
        logic [1:0]  go;
        logic [6:0]  asg;
        logic [3:0]  gate;
    } pmrc_ctrl_t;

    typedef struct packed {
        logic [3:0] pin;
        logic       lock;
        logic [3:0] up;
        logic [3:0] low;
        logic [3:0] oc;
        logic       warn;
        logic       trip;
        logic       okpin;
    } pmrc_in_t;

    typedef struct packed {
        pmrc_in_t    s1;
        pmrc_in_t    s2;
        pmrc_ctrl_t  c;
        logic [2:0]  pos;
        logic [11:0] scnt;
        logic [19:0] mcnt;
        logic [9:0]  dcnt;
        logic [15:0] cur;
        logic [17:0] rtmr;
        logic [3:0]  on;
        logic [3:0]  pg;
        logic [3:0]  dis;
        logic [10:0] prev;
        logic [10:0] lat;
        logic        rel;
        logic        oe;
        logic        rdy;
        logic        err;
        logic [31:0] rdata;
    } pmrc_st_t;

    // Codes 0x30 give 1.2 V and 0x18 give 0.9 V.
    localparam logic [15:0] CUR_RST = 16'h3030;
    localparam pmrc_ctrl_t CTRL_RST = '{
        en: 4'h0, slot: 12'h003, prim: 16'h3030, alt: 16'h1818,
        dly: 3'h0, rate: 2'h0, go: 2'h0, asg: 7'h12, gate: 4'h2};
    // History starts at the idle source levels, so reset raises no event.
    localparam pmrc_st_t ST_RST = '{c: CTRL_RST, cur: CUR_RST,
        pg: 4'hF, prev: 11'h00F, dis: 4'hF, oe: 1'b1, default: '0};

endpackage

// file: logic/pmrc_core.sv
`timescale 1ns/10ps
module pmrc_core #(
    parameter int unsigned MS_CYCLES = pmrc_pkg::MS_CYC_DEF
) (
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        CE_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [3:0]  RAIL_EN_PIN_I,
    input  wire logic        LOCKOUT_I,
    input  wire logic [3:0]  RAIL_UP_I,
    input  wire logic [3:0]  RAIL_LOW_I,
    input  wire logic [3:0]  OVERCUR_I,
    input  wire logic        THERM_WARN_I,
    input  wire logic        THERM_TRIP_I,
    input  wire logic        SUPPLY_OK_I,
    output logic             SUPPLY_OK_O,
    output logic             SUPPLY_OK_OE_O,
    output logic [3:0]       RAIL_ON_O,
    output logic [3:0]       DISCHARGE_O,
    output logic [15:0]      BUCK_REF_O
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pmrc_pkg::pmrc_st_t q;
    pmrc_pkg::pmrc_st_t n;
    pmrc_pkg::pmrc_in_t in_now;
    logic        setup;
    logic        acc;
    logic        hit;
    logic        rst_w;
    logic        tick;
    logic        and_ok;
    logic        done;
    logic [31:0] rd;
    logic [10:0] src;
    logic [10:0] edg;
    logic [10:0] clr;
    logic [15:0] tgt;
    logic [1:0]  rise;
    logic [8:0]  lim;
    logic [6:0]  gv;

    assign in_now = '{pin: RAIL_EN_PIN_I, lock: LOCKOUT_I, up: RAIL_UP_I,
        low: RAIL_LOW_I, oc: OVERCUR_I, warn: THERM_WARN_I,
        trip: THERM_TRIP_I, okpin: SUPPLY_OK_I};

    always_comb begin
        n     = q;
        rd    = '0;
        hit   = 1'b1;
        clr   = '0;
        rst_w = 1'b0;
        n.s1  = in_now;
        n.s2  = q.s1;
        done  = (q.pos == pmrc_pkg::SEQ_END);
        setup = PSEL_I && !PENABLE_I;
        acc   = PSEL_I && PENABLE_I && q.rdy;

        // --------------------------------------------------------------
        // Event detection
        // --------------------------------------------------------------
        src = {q.s2.trip, q.s2.warn, q.s2.oc, q.s2.lock, q.pg};
        edg = ((src ^ q.prev) & ~pmrc_pkg::RISE_ONLY)
            | (src & ~q.prev & pmrc_pkg::RISE_ONLY);

        // --------------------------------------------------------------
        // Converter reference ramps
        // --------------------------------------------------------------
        lim = pmrc_pkg::ramp_lim(q.c.rate);
        for (int b = 0; b < 2; b++) begin
            tgt[8*b +: 8] = q.c.go[b] ? q.c.alt[8*b +: 8]
                                      : q.c.prim[8*b +: 8];
            rise[b] = tgt[8*b +: 8] > q.cur[8*b +: 8];
            // Any change of the selected code reopens the ramp.
            if (tgt[8*b +: 8] == q.cur[8*b +: 8]) begin
                n.rtmr[9*b +: 9] = '0;
            end else if (q.rtmr[9*b +: 9] >= lim) begin
                n.rtmr[9*b +: 9] = '0;
                n.cur[8*b +: 8] = rise[b]
                    ? 8'(q.cur[8*b +: 8] + 8'h01)
                    : 8'(q.cur[8*b +: 8] - 8'h01);
            end else begin
                n.rtmr[9*b +: 9] = 9'(q.rtmr[9*b +: 9] + 9'h001);
            end
        end

        // --------------------------------------------------------------
        // Register read decode
        // --------------------------------------------------------------
        case (PADDR_I)
            pmrc_pkg::A_ENABLE: rd = 32'(q.c.en);
            pmrc_pkg::A_SLOT:   rd = 32'(q.c.slot);
            pmrc_pkg::A_PRIM:   rd = 32'(q.c.prim);
            pmrc_pkg::A_ALT:    rd = 32'(q.c.alt);
            pmrc_pkg::A_TIME:   rd = 32'({q.c.dly, q.c.rate, q.c.go});
            pmrc_pkg::A_ASSIGN: rd = 32'(q.c.asg);
            pmrc_pkg::A_GATE:   rd = 32'(q.c.gate);
            pmrc_pkg::A_RESET:  rd = '0;
            pmrc_pkg::A_LIVE_A: rd = 32'({q.s2.pin, 3'h0, src[4:0]});
            pmrc_pkg::A_LIVE_B: rd = 32'(src[10:5]);
            pmrc_pkg::A_LAT_A:  rd = 32'(q.lat[4:0]);
            pmrc_pkg::A_LAT_B:  rd = 32'(q.lat[10:5]);
            pmrc_pkg::A_STATUS: rd = 32'({q.s2.okpin, rise, done, q.on});
            pmrc_pkg::A_REF:    rd = 32'(q.cur);
            default:            hit = 1'b0;
        endcase
        // Reads are captured in setup, so pready needs no wait state.
        n.rdy   = setup;
        n.err   = setup && !hit;
        n.rdata = setup ? rd : '0;
        // Only bits already returned to the host are cleared; an edge that
        // lands after the data was captured waits for the next read.
        if (acc && !PWRITE_I && PADDR_I == pmrc_pkg::A_LAT_A) begin
            clr[4:0] = q.rdata[4:0];
        end
        if (acc && !PWRITE_I && PADDR_I == pmrc_pkg::A_LAT_B) begin
            clr[10:5] = q.rdata[5:0];
        end
        n.prev = src;
        // A new edge in the clearing cycle survives the clear.
        n.lat  = (q.lat & ~clr) | edg;

        // --------------------------------------------------------------
        // Power-up sequencer and rail enables
        // --------------------------------------------------------------
        if (!done) begin
            if (q.scnt == pmrc_pkg::SLOT_CYC - 12'h001) begin
                n.scnt = '0;
                n.pos  = 3'(q.pos + 3'h1);
            end else begin
                n.scnt = 12'(q.scnt + 12'h001);
            end
        end
        for (int i = 0; i < 4; i++) begin
            n.on[i] = (q.pos > q.c.slot[3*i +: 3])
                && (q.s2.pin[i] || q.c.en[i]);
            if (!n.on[i]) begin
                n.pg[i] = 1'b1;
            end else if (!q.on[i]) begin
                n.pg[i] = 1'b0;
            end else if (q.s2.low[i]) begin
                n.pg[i] = 1'b0;
            end else if (q.s2.up[i]) begin
                n.pg[i] = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // Supply-ok combination and release delay
        // --------------------------------------------------------------
        gv     = {~rise, done, q.pg};
        and_ok = &(gv | ~q.c.asg);
        tick   = (q.mcnt == 20'(MS_CYCLES - 1));
        n.mcnt = tick ? '0 : 20'(q.mcnt + 20'h00001);
        if (!and_ok) begin
            // Restart the ms timer so the delay counts whole milliseconds.
            n.mcnt = '0;
            n.rel  = 1'b0;
            n.dcnt = '0;
        end else if (!q.rel) begin
            if (q.dcnt >= pmrc_pkg::dly_ms(q.c.dly)) begin
                n.rel = 1'b1;
            end else if (tick) begin
                n.dcnt = 10'(q.dcnt + 10'h001);
            end
        end
        n.oe  = !q.rel || (|(q.c.gate & ~q.on));
        n.dis = '0;

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (acc && PWRITE_I) begin
            case (PADDR_I)
                pmrc_pkg::A_ENABLE: n.c.en = PWDATA_I[3:0];
                pmrc_pkg::A_SLOT:   n.c.slot = PWDATA_I[11:0];
                pmrc_pkg::A_PRIM:   n.c.prim = PWDATA_I[15:0];
                pmrc_pkg::A_ALT:    n.c.alt = PWDATA_I[15:0];
                pmrc_pkg::A_TIME: begin
                    n.c.go   = PWDATA_I[pmrc_pkg::F_GO +: 2];
                    n.c.rate = PWDATA_I[pmrc_pkg::F_RATE +: 2];
                    n.c.dly  = PWDATA_I[pmrc_pkg::F_DLY +: 3];
                end
                pmrc_pkg::A_ASSIGN: n.c.asg = PWDATA_I[6:0];
                pmrc_pkg::A_GATE:   n.c.gate = PWDATA_I[3:0];
                pmrc_pkg::A_RESET:  rst_w = 1'b1;
                default:            rst_w = 1'b0;
            endcase
        end
        // A reset write acts like a fresh supply: defaults and new sequence.
        if (rst_w) begin
            n.c    = pmrc_pkg::CTRL_RST;
            n.pos  = '0;
            n.scnt = '0;
            n.cur  = pmrc_pkg::CUR_RST;
        end

        // --------------------------------------------------------------
        // Supply lockout; event history is kept so its edges are seen
        // --------------------------------------------------------------
        if (q.s2.lock) begin
            n.c    = pmrc_pkg::CTRL_RST;
            n.pos  = '0;
            n.scnt = '0;
            n.cur  = pmrc_pkg::CUR_RST;
            n.rtmr = '0;
            n.on   = '0;
            n.pg   = 4'hF;
            n.dis  = 4'hF;
            n.oe   = 1'b1;
            n.rel  = 1'b0;
            n.dcnt = '0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            q <= pmrc_pkg::ST_RST;
        end else if (CE_I) begin
            q <= n;
        end
    end

    assign PRDATA_O       = q.rdata;
    assign PREADY_O       = q.rdy;
    assign PSLVERR_O      = q.err;
    assign SUPPLY_OK_O    = 1'b0;
    assign SUPPLY_OK_OE_O = q.oe;
    assign RAIL_ON_O      = q.on;
    assign DISCHARGE_O    = q.dis;
    assign BUCK_REF_O     = q.cur;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I || !CE_I);

    sequence apb_wr(logic [7:0] a);
        PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == a;
    endsequence

    sequence apb_rd(logic [7:0] a);
        PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == a;
    endsequence

    rail_or_on_a: assert property (
        (done && q.s2.pin[0] && !q.s2.lock) [*2] |-> RAIL_ON_O[0])
        else $error("rail stayed off with pin high after sequence");

    rail_off_a: assert property (
        (!q.s2.pin[2] && !q.c.en[2]) |=> !RAIL_ON_O[2])
        else $error("rail on with pin low and enable bit clear");

    lock_off_a: assert property (
        q.s2.lock |=> (RAIL_ON_O == 4'h0) && SUPPLY_OK_OE_O
            && (DISCHARGE_O == 4'hF) && (q.c == pmrc_pkg::CTRL_RST))
        else $error("lockout did not shut down rails");

    regs_reset_a: assert property (
        apb_wr(pmrc_pkg::A_RESET) |=> q.c == pmrc_pkg::CTRL_RST)
        else $error("reset write did not restore defaults");

    ramp_step_a: assert property (
        (rise[0] && q.rtmr[8:0] == lim && !q.s2.lock && !rst_w)
            |=> q.cur[7:0] == 8'($past(q.cur[7:0]) + 8'h01))
        else $error("reference did not step up one code");

    ramp_hold_a: assert property (
        (rise[1] && q.rtmr[17:9] < lim && !q.s2.lock && !rst_w)
            |=> $stable(q.cur[15:8]))
        else $error("reference stepped before period end");

    good_off_a: assert property (
        (q.pg | q.on) == 4'hF)
        else $error("power-good low on a rail that is off");

    good_drop_a: assert property (
        (q.on[1] && q.s2.low[1]) ##1 q.on[1] |-> !q.pg[1])
        else $error("power-good stayed high below threshold");

    gate_low_a: assert property (
        (q.c.gate[1] && !q.on[1]) |=> SUPPLY_OK_OE_O)
        else $error("supply-ok released with gated rail off");

    event_set_a: assert property (
        edg[0] |=> q.lat[0])
        else $error("source edge not latched");

    latch_clr_a: assert property (
        (apb_rd(pmrc_pkg::A_LAT_A) and (edg[4:0] == 5'h00))
            |=> (q.lat[4:0] & $past(PRDATA_O[4:0])) == 5'h00)
        else $error("latched register not cleared by read");

endmodule

// file: verif/pmrc_plant.sv
`timescale 1ns/10ps
module pmrc_plant #(
    parameter int UP_DLY = 40
) (
    input  wire logic       clk_i,
    input  wire logic [3:0] rail_on_i,
    input  wire logic [3:0] droop_i,
    input  wire logic       ok_o_i,
    input  wire logic       ok_oe_i,
    output logic [3:0]      rail_up_o,
    output logic [3:0]      rail_low_o,
    output logic            ok_wire_o
);
    int cnt [4] = '{0, 0, 0, 0};

    // The pin has a pull-up, so a released pin reads high.
    assign ok_wire_o  = ok_oe_i ? ok_o_i : 1'b1;
    assign rail_low_o = droop_i & rail_on_i;
    initial rail_up_o = 4'h0;

    // Soft start: a rail reaches its level UP_DLY + 1 cycles after enable.
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= rail_on_i[i] ? cnt[i] + 1 : 0;
            rail_up_o[i] <= rail_on_i[i] && !droop_i[i] && cnt[i] >= UP_DLY;
        end
    end
endmodule

// file: verif/test_pmic_rail_control_core.sv
`timescale 1ns/10ps
module test_pmic_rail_control_core;
    logic        clk    = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel   = 1'b0;
    logic        pen    = 1'b0;
    logic        pwr    = 1'b0;
    logic [7:0]  paddr  = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pin    = 4'h0;
    logic        lock   = 1'b0;
    logic [3:0]  up;
    logic [3:0]  low;
    logic [3:0]  droop  = 4'h0;
    logic [3:0]  oc     = 4'h0;
    logic        warn   = 1'b0;
    logic        trip   = 1'b0;
    logic        okw;
    logic        ok_o;
    logic        ok_oe;
    logic [3:0]  on;
    logic [3:0]  dis;
    logic [15:0] bref;
    logic [31:0] rd;
    logic [7:0]  x;
    logic [31:0] seed   = 32'h00014219;
    int          fail_count = 0;
    int          checked    = 0;
    int          cyc = 0;
    int          n;
    int          p;
    int          per [4] = '{33, 66, 133, 266};
    localparam logic [7:0]  DA [7] = '{pmrc_pkg::A_ENABLE,
        pmrc_pkg::A_SLOT, pmrc_pkg::A_PRIM, pmrc_pkg::A_ALT,
        pmrc_pkg::A_TIME, pmrc_pkg::A_ASSIGN, pmrc_pkg::A_GATE};
    localparam logic [31:0] DV [7] = '{32'h0, 32'h3, 32'h3030,
        32'h1818, 32'h0, 32'h12, 32'h2};

    always #20 clk = ~clk;
    always @(posedge clk) cyc <= arst_n ? cyc + 1 : 0;

    pmrc_core #(.MS_CYCLES(10)) dut_u (.CLK_I(clk), .ARST_N_I(arst_n),
        .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .RAIL_EN_PIN_I(pin),
        .LOCKOUT_I(lock), .RAIL_UP_I(up), .RAIL_LOW_I(low),
        .OVERCUR_I(oc), .THERM_WARN_I(warn), .THERM_TRIP_I(trip),
        .SUPPLY_OK_I(okw), .SUPPLY_OK_O(ok_o), .SUPPLY_OK_OE_O(ok_oe),
        .RAIL_ON_O(on), .DISCHARGE_O(dis), .BUCK_REF_O(bref));

    pmrc_plant plant_u (.clk_i(clk), .rail_on_i(on), .droop_i(droop),
        .ok_o_i(ok_o), .ok_oe_i(ok_oe), .rail_up_o(up),
        .rail_low_o(low), .ok_wire_o(okw));

    // --------
    // Helpers
    // --------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic tmo(input string nm);
        $display("Error %s expected done seen timeout", nm);
        fail_count++;
        close_out();
    endtask

    // Request held until pready is sampled high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (pready !== 1'b1) tmo("pready");
    endtask

    task automatic chk_defaults();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, DA[i], 32'h0);
            chk("default value", DV[i], rd);
        end
    endtask

    initial begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        chk_defaults();
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, pslverr});
        apb(1'b1, pmrc_pkg::A_ENABLE, 32'h1);
        $display("End of test: defaults");

        n = 0;
        while (on[0] !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) tmo("rail0 on");
        chk("slot time", 32'h1, 32'(cyc > 12780 && cyc < 12830));
        chk("others off", 32'h0, 32'(on[3:1]));
        for (int k = 0; k < 4; k++) begin
            pin[1] <= 1'b0;
            apb(1'b1, pmrc_pkg::A_ENABLE, 32'h1);
            repeat (6) @(posedge clk);
            pin[1] <= k[0];
            apb(1'b1, pmrc_pkg::A_ENABLE, {30'h0, k[1], 1'b1});
            repeat (4) @(posedge clk);
            chk("rail1 on", 32'(k != 0), 32'(on[1]));
            apb(1'b0, pmrc_pkg::A_LIVE_A, 32'h0);
            chk("pin sense", 32'(k[0]), 32'(rd[9]));
            chk("good low on enable", 32'(k == 0), 32'(rd[1]));
        end
        chk("reset holds ok", 32'h1, 32'(ok_oe));
        n = 0;
        do begin
            apb(1'b0, pmrc_pkg::A_STATUS, 32'h0);
            n++;
        end while (rd[4] !== 1'b1 && n < 3000);
        if (n >= 3000) tmo("sequence");
        repeat (8) @(posedge clk);
        chk("ok released", 32'h0, 32'(ok_oe));
        apb(1'b0, pmrc_pkg::A_LIVE_A, 32'h0);
        chk("good after level", 32'h1, 32'(rd[1]));
        apb(1'b0, pmrc_pkg::A_STATUS, 32'h0);
        chk("pin level", 32'h1, 32'(rd[7]));
        $display("End of test: enables");

        apb(1'b0, pmrc_pkg::A_LAT_A, 32'h0);
        apb(1'b0, pmrc_pkg::A_LAT_A, 32'h0);
        chk("latch cleared", 32'h0, 32'(rd[4:0]));
        droop[1] <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b0, pmrc_pkg::A_LIVE_A, 32'h0);
        chk("good on droop", 32'h0, 32'(rd[1]));
        chk("ok on droop", 32'h1, 32'(ok_oe));
        droop[1] <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, pmrc_pkg::A_LAT_A, 32'h0);
        chk("good edges", 32'h02, 32'(rd[4:0]));
        x = 8'(rnd()) | 8'h04;
        oc   <= x[3:0];
        warn <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, pmrc_pkg::A_LIVE_B, 32'h0);
        chk("live b", {26'h0, 2'b01, x[3:0]}, 32'(rd[5:0]));
        apb(1'b0, pmrc_pkg::A_LAT_B, 32'h0);
        chk("rise events", {26'h0, 2'b01, x[3:0]}, 32'(rd[5:0]));
        oc   <= 4'h0;
        warn <= 1'b0;
        trip <= 1'b1;
        repeat (5) @(posedge clk);
        apb(1'b0, pmrc_pkg::A_LAT_B, 32'h0);
        chk("fall events", {26'h0, 2'b11, x[3:2], 2'b00}, 32'(rd[5:0]));
        trip <= 1'b0;
        repeat (5) @(posedge clk);
        apb(1'b0, pmrc_pkg::A_LAT_B, 32'h0);
        $display("End of test: events");

        x = 8'h20 | (8'(rnd()) & 8'h1F);
        apb(1'b1, pmrc_pkg::A_PRIM, {16'h0, 8'h30, x});
        n = 0;
        while (bref[7:0] !== x && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) tmo("rewrite ramp");
        chk("rewrite ramp", {24'h0, x}, 32'(bref[7:0]));
        apb(1'b1, pmrc_pkg::A_PRIM, 32'h3030);
        apb(1'b1, pmrc_pkg::A_ASSIGN, 32'h32);
        for (int r = 0; r < 4; r++) begin
            p = per[r];
            apb(1'b1, pmrc_pkg::A_TIME, 32'(r << 2) | 32'h3);
            n = 0;
            while (bref !== 16'h1818 && n < 9000) begin
                @(posedge clk);
                n++;
            end
            if (n >= 9000) tmo("alternate code");
            chk("alternate code", 32'h1818, 32'(bref));
            apb(1'b1, pmrc_pkg::A_TIME, 32'(r << 2));
            n = 0;
            while (bref !== 16'h3030 && n < 9000) begin
                @(posedge clk);
                n++;
                if (n == 12 * p) chk("ramp ok", 32'h1, 32'(ok_oe));
            end
            if (n >= 9000) tmo("primary code");
            chk("ramp time", 32'h1, 32'(n > 23 * p && n < 25 * p));
        end
        repeat (8) @(posedge clk);
        chk("ok after ramp", 32'h0, 32'(ok_oe));
        $display("End of test: voltage scaling");

        apb(1'b1, pmrc_pkg::A_ENABLE, 32'h1);
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, pmrc_pkg::A_TIME, 32'(c << 4));
            pin[1] <= 1'b0;
            repeat (50) @(posedge clk);
            chk("gate off", 32'h1, 32'(ok_oe));
            pin[1] <= 1'b1;
            n = 0;
            while (up[1] !== 1'b1 && n < 200) begin
                @(posedge clk);
                n++;
            end
            if (n >= 200) tmo("rail1 up");
            n = 0;
            while (ok_oe !== 1'b0 && n < 2000) begin
                @(posedge clk);
                n++;
            end
            if (n >= 2000) tmo("release");
            p = 10 * (4 << c);
            chk("release delay", 32'h1, 32'(n >= p && n <= p + 10));
        end
        $display("End of test: release delay");

        lock <= 1'b1;
        repeat (4) @(posedge clk);
        chk("lockout rails", 32'h0, 32'(on));
        chk("discharge", 32'hF, 32'(dis));
        chk("lockout ok", 32'h1, 32'(ok_oe));
        chk("ok data", 32'h0, 32'(ok_o));
        lock <= 1'b0;
        repeat (4) @(posedge clk);
        chk("discharge off", 32'h0, 32'(dis));
        apb(1'b0, pmrc_pkg::A_ENABLE, 32'h0);
        chk("lockout reset", 32'h0, rd);
        apb(1'b0, pmrc_pkg::A_LAT_A, 32'h0);
        chk("lockout event", 32'h1, 32'(rd[4]));
        apb(1'b1, pmrc_pkg::A_PRIM, rnd() & 32'hFFFF);
        apb(1'b1, pmrc_pkg::A_SLOT, 32'h249);
        apb(1'b0, pmrc_pkg::A_SLOT, 32'h0);
        chk("slot write", 32'h249, rd);
        apb(1'b1, pmrc_pkg::A_GATE, 32'hF);
        apb(1'b1, pmrc_pkg::A_RESET, 32'h1);
        chk_defaults();
        $display("End of test: lockout and reset");
        close_out();
    end
endmodule
